// File: host_model.sv
/*
 * Host model: single-byte register reads and writes on the strobe port.
 * Assumes calls start after the reset release delay.
 */
`timescale 1ns/10ps
module host_model
    import touch_irq_pkg::*;
(
    input  wire logic      clk_i,
    input  wire reg_byte_t rdata_i,
    output reg_byte_t      addr_o,
    output reg_byte_t      wdata_o,
    output logic           wr_o,
    output logic           rd_o
);
    initial {addr_o, wdata_o, wr_o, rd_o} = '0;
    // Ones clear status or flag bits, zeros keep them
    task automatic wr(input reg_byte_t a, input reg_byte_t d);
        @(negedge clk_i);
        {addr_o, wdata_o, wr_o} = {a, d, 1'h1};
        @(negedge clk_i);
        // Released bus shows inverted values so stale data never looks live
        {addr_o, wdata_o, wr_o} = {~a, ~d, 1'h0};
    endtask : wr
    task automatic rd(input reg_byte_t a, output reg_byte_t d);
        @(negedge clk_i);
        {addr_o, rd_o} = {a, 1'h1};
        @(negedge clk_i);
        {addr_o, rd_o} = {~a, 1'h0};
        @(negedge clk_i);
        d = rdata_i;
    endtask : rd
endmodule : host_model

// File: pin_flag_bank.sv
/*
 * Per-pin sticky interrupt flags with write-one-to-clear.
 * Assumes event pulses and clear mask arrive on the same clock.
 */
`timescale 1ns/10ps
module pin_flag_bank
    import touch_irq_pkg::*;
(
    input  wire logic      clk_i,
    input  wire logic      rst_n_i,
    input  wire reg_byte_t evt_i,
    input  wire reg_byte_t clr_i,
    output reg_byte_t      flags_o
);
`include "touch_irq_map.svh"

    reg_byte_t flag_reg;
    reg_byte_t flag_next;

    genvar g;
    generate
        for (g = 0; g < 8; g = g + 1)
        begin : g_flag
            // Flags follow their events regardless of the mask; set beats clear
            always_comb
            begin
                flag_next[g] = evt_i[g] | (flag_reg[g] & ~clr_i[g]);
            end
        end
    endgenerate

    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            flag_reg <= `PIN_IRQ_FLAGS_RESET;
        else
            flag_reg <= flag_next;
    end

    assign flags_o = flag_reg;

endmodule : pin_flag_bank

// File: touch_expander_irq_core.sv
/*
 * Two-tier interrupt block: source enables, sticky source status, per-pin
 * mask and flags, global gate and pin signalling type/polarity.
 * Assumes a serial interface decoder issues single-cycle register read and
 * write strobes, and that all event inputs are same-clock one-cycle pulses.
 */
`timescale 1ns/10ps
module touch_expander_irq_core
    import touch_irq_pkg::*;
(
    input  wire logic      ref_clk_i,
    input  wire logic      arst_n_i,
    input  wire reg_byte_t reg_addr_i,
    input  wire reg_byte_t reg_wdata_i,
    input  wire logic      reg_wr_i,
    input  wire logic      reg_rd_i,
    output reg_byte_t      reg_rdata_o,
    input  wire logic      contact_sensed_evt_i,
    input  wire logic      queue_empty_evt_i,
    input  wire logic      queue_full_evt_i,
    input  wire logic      queue_overrun_evt_i,
    input  wire logic      conv_evt_i,
    input  wire reg_byte_t pin_evt_i,
    input  wire reg_byte_t queue_fill_i,
    input  wire reg_byte_t queue_threshold_i,
    output logic           irq_o
);
`include "touch_irq_map.svh"

    localparam pulse_cnt_t PULSE_LEN = pulse_cnt_t'(`EDGE_PULSE_CYCLES);

    logic       rst_s1_reg;
    logic       rst_n_reg;

    always_ff @(posedge ref_clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            rst_s1_reg <= 1'b0;
            rst_n_reg  <= 1'b0;
        end
        else
        begin
            rst_s1_reg <= 1'b1;
            rst_n_reg  <= rst_s1_reg;
        end
    end

    logic [2:0] ctrl_reg;
    logic [2:0] ctrl_next;
    reg_byte_t  src_en_reg;
    reg_byte_t  src_en_next;
    reg_byte_t  src_sta_reg;
    reg_byte_t  src_sta_next;
    reg_byte_t  pin_mask_reg;
    reg_byte_t  pin_mask_next;
    logic       level_armed_reg;
    logic       level_armed_next;
    reg_byte_t  rdata_reg;
    reg_byte_t  rdata_next;
    reg_byte_t  src_evt;
    reg_byte_t  sta_clr;
    reg_byte_t  pin_clr;
    reg_byte_t  pin_flags;
    logic       level_hit;

    pin_flag_bank u_pin_flags
    (
        .clk_i   (ref_clk_i),
        .rst_n_i (rst_n_reg),
        .evt_i   (pin_evt_i),
        .clr_i   (pin_clr),
        .flags_o (pin_flags)
    );

    always_comb
    begin
        ctrl_next     = ctrl_reg;
        src_en_next   = src_en_reg;
        pin_mask_next = pin_mask_reg;
        sta_clr       = 8'h00;
        pin_clr       = 8'h00;
        if (reg_wr_i)
        begin
            case (reg_addr_i)
                `IRQ_CTRL_ADDR:       ctrl_next     = reg_wdata_i[2:0];
                `IRQ_SOURCE_EN_ADDR:  src_en_next   = reg_wdata_i;
                `IRQ_SOURCE_STA_ADDR: sta_clr       = reg_wdata_i;
                `PIN_IRQ_MASK_ADDR:   pin_mask_next = reg_wdata_i;
                `PIN_IRQ_FLAGS_ADDR:  pin_clr       = reg_wdata_i;
                default:              sta_clr       = 8'h00;
            endcase
        end
        src_en_next[`SRC_RESERVED_BIT] = 1'b0;
    end

    // Threshold status fires once per crossing, not while the level sits high
    always_comb
    begin
        level_hit        = level_armed_reg && (queue_fill_i == queue_threshold_i);
        level_armed_next = level_armed_reg;
        if (level_hit)
            level_armed_next = 1'b0;
        else if (queue_fill_i < queue_threshold_i)
            level_armed_next = 1'b1;
    end

    always_comb
    begin
        src_evt                    = 8'h00;
        src_evt[`SRC_PIN_BIT]      = |(pin_evt_i & pin_mask_reg);
        src_evt[`SRC_CONV_BIT]     = conv_evt_i;
        src_evt[`SRC_EMPTY_BIT]    = queue_empty_evt_i;
        src_evt[`SRC_FULL_BIT]     = queue_full_evt_i;
        src_evt[`SRC_OVERRUN_BIT]  = queue_overrun_evt_i;
        src_evt[`SRC_LEVEL_BIT]    = level_hit;
        src_evt[`SRC_CONTACT_BIT]  = contact_sensed_evt_i;
        // Latched whatever the enables say; a new event beats a same-cycle clear
        src_sta_next = src_evt | (src_sta_reg & ~sta_clr);
    end

    always_comb
    begin
        rdata_next = rdata_reg;
        if (reg_rd_i)
        begin
            case (reg_addr_i)
                `IRQ_CTRL_ADDR:       rdata_next = {5'h00, ctrl_reg};
                `IRQ_SOURCE_EN_ADDR:  rdata_next = src_en_reg;
                `IRQ_SOURCE_STA_ADDR: rdata_next = src_sta_reg;
                `PIN_IRQ_MASK_ADDR:   rdata_next = pin_mask_reg;
                `PIN_IRQ_FLAGS_ADDR:  rdata_next = pin_flags;
                default:              rdata_next = 8'h00;
            endcase
        end
    end

    always_ff @(posedge ref_clk_i or negedge rst_n_reg)
    begin
        if (!rst_n_reg)
        begin
            ctrl_reg        <= `IRQ_CTRL_RESET;
            src_en_reg      <= `IRQ_SOURCE_EN_RESET;
            src_sta_reg     <= `IRQ_SOURCE_STA_RESET;
            pin_mask_reg    <= `PIN_IRQ_MASK_RESET;
            level_armed_reg <= 1'b1;
            rdata_reg       <= 8'h00;
        end
        else
        begin
            ctrl_reg        <= ctrl_next;
            src_en_reg      <= src_en_next;
            src_sta_reg     <= src_sta_next;
            pin_mask_reg    <= pin_mask_next;
            level_armed_reg <= level_armed_next;
            rdata_reg       <= rdata_next;
        end
    end

    // Interrupt pin signalling
    pin_state_e pin_state_reg;
    pin_state_e pin_state_next;
    pulse_cnt_t pulse_cnt_reg;
    pulse_cnt_t pulse_cnt_next;
    logic       pending_reg;
    logic       pending;
    logic       irq_reg;
    logic       irq_next;
    logic       active;

    always_comb
    begin
        pending        = ctrl_reg[`CTRL_GLOBAL_BIT] && |(src_sta_reg & src_en_reg);
        pin_state_next = pin_state_reg;
        pulse_cnt_next = pulse_cnt_reg;
        active         = 1'b0;
        case (pin_state_reg)
            PIN_IDLE:
            begin
                if (pending && !ctrl_reg[`CTRL_TYPE_BIT])
                    pin_state_next = PIN_LEVEL;
                else if (pending && !pending_reg)
                begin
                    pin_state_next = PIN_PULSE;
                    pulse_cnt_next = PULSE_LEN;
                end
            end
            PIN_LEVEL:
            begin
                active = pending;
                if (!pending || ctrl_reg[`CTRL_TYPE_BIT])
                    pin_state_next = PIN_IDLE;
            end
            PIN_PULSE:
            begin
                // A dropped global gate cuts the pulse short
                active         = ctrl_reg[`CTRL_GLOBAL_BIT];
                pulse_cnt_next = pulse_cnt_reg - 5'h01;
                if (pulse_cnt_reg == 5'h01 || !ctrl_reg[`CTRL_GLOBAL_BIT])
                    pin_state_next = PIN_IDLE;
            end
            default:
                pin_state_next = PIN_IDLE;
        endcase
        irq_next = active ~^ ctrl_reg[`CTRL_POLARITY_BIT];
    end

    always_ff @(posedge ref_clk_i or negedge rst_n_reg)
    begin
        if (!rst_n_reg)
        begin
            pin_state_reg <= PIN_IDLE;
            pulse_cnt_reg <= 5'h00;
            pending_reg   <= 1'b0;
            // Reset polarity is active low, so the idle level is high; a low pin here would look like an interrupt
            irq_reg       <= 1'b1;
        end
        else
        begin
            pin_state_reg <= pin_state_next;
            pulse_cnt_reg <= pulse_cnt_next;
            pending_reg   <= pending;
            irq_reg       <= irq_next;
        end
    end

    assign reg_rdata_o = rdata_reg;
    assign irq_o       = irq_reg;

endmodule : touch_expander_irq_core

// File: touch_expander_irq_core_tb_top.sv
/*
 * Self-checking bench of the interrupt block with a host model.
 * Assumes the package and map header are compiled first.
 */
`timescale 1ns/10ps
`include "touch_irq_map.svh"
module touch_expander_irq_core_tb_top;
    import touch_irq_pkg::*;
    logic       ref_clk_i, arst_n_i, wr, rd, irq;
    logic [4:0] ev;
    reg_byte_t  addr, wdata, rdata, pin, fill, thr, r, d, m, p, w;
    int         errors, checked, seed, i, n;
    touch_expander_irq_core DUT (.ref_clk_i(ref_clk_i), .arst_n_i(arst_n_i), .reg_addr_i(addr),
        .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata),
        .contact_sensed_evt_i(ev[0]), .queue_overrun_evt_i(ev[1]), .queue_full_evt_i(ev[2]),
        .queue_empty_evt_i(ev[3]), .conv_evt_i(ev[4]), .pin_evt_i(pin), .queue_fill_i(fill),
        .queue_threshold_i(thr), .irq_o(irq));
    host_model host (.clk_i(ref_clk_i), .rdata_i(rdata), .addr_o(addr), .wdata_o(wdata),
        .wr_o(wr), .rd_o(rd));
    function automatic reg_byte_t sta_bit(input int k);
        sta_bit = 8'h01 << ((k == 0) ? 0 : (k == 4) ? 6 : k + 1);
    endfunction : sta_bit
    task automatic chk(input reg_byte_t got, input reg_byte_t exp);
        checked++;
        if (got !== exp)
        begin
            errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic rdchk(input reg_byte_t a, input reg_byte_t e);
        host.rd(a, r);
        chk(r, e);
    endtask : rdchk
    task automatic pulse(input logic [4:0] e, input reg_byte_t pe);
        @(negedge ref_clk_i);
        {ev, pin} = {e, pe};
        @(negedge ref_clk_i);
        {ev, pin} = '0;
    endtask : pulse
    task automatic reach(input reg_byte_t from);
        @(negedge ref_clk_i);
        fill = from;
        @(negedge ref_clk_i);
        fill = thr;
    endtask : reach
    task automatic await(input logic lvl);
        n = 0;
        while (irq !== lvl && n < 8)
        begin
            @(negedge ref_clk_i);
            n++;
        end
        chk({7'h0, irq}, {7'h0, lvl});
        // A pin that never reaches its level ends the run at once
        if (irq !== lvl)
            results();
    endtask : await
    task automatic results;
        $display("compares %0d mismatches %0d", checked, errors);
        if (errors == 0 && checked > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : results
    initial
    begin
        ref_clk_i = 1'h0;
        forever #20 ref_clk_i = ~ref_clk_i;
    end
    initial
    begin
        {arst_n_i, ev, pin, fill, errors, checked} = '0;
        thr  = 8'h05;
        seed = 32'hC7EC;
        repeat (2) @(negedge ref_clk_i);
        arst_n_i = 1'h1;
        repeat (3) @(posedge ref_clk_i);
        rdchk(8'h0B, 8'h10);
        rdchk(8'h0C, 8'h10);
        rdchk(8'h0A, 8'h00);
        rdchk(8'h20, 8'h00);
        chk({7'h0, irq}, 8'h01);
        d = $random(seed);
        m = $random(seed);
        host.wr(8'h0A, d);
        host.wr(8'h0C, m);
        rdchk(8'h0A, d & 8'hDF);
        rdchk(8'h0C, m);
        host.wr(8'h0B, 8'hFF);
        rdchk(8'h0B, 8'h00);
        for (i = 0; i < 5; i++)
        begin
            pulse(5'h01 << i, 8'h00);
            rdchk(8'h0B, sta_bit(i));
            host.wr(8'h0B, ~sta_bit(i));
            rdchk(8'h0B, sta_bit(i));
            host.wr(8'h0B, sta_bit(i));
            rdchk(8'h0B, 8'h00);
        end
        $display("test sources done");
        thr = 8'h02 + (8'($random(seed)) & 8'h3F);
        reach(thr - 8'h01);
        rdchk(8'h0B, 8'h02);
        host.wr(8'h0B, 8'h02);
        reach(thr + 8'h01);
        rdchk(8'h0B, 8'h00);
        reach(thr - 8'h01);
        rdchk(8'h0B, 8'h02);
        host.wr(8'h0B, 8'h02);
        $display("test threshold done");
        p = $random(seed) | 8'h01;
        pulse(5'h00, p);
        rdchk(8'h0D, p);
        rdchk(8'h0B, {|(p & m), 7'h00});
        w = $random(seed);
        host.wr(8'h0D, w);
        rdchk(8'h0D, p & ~w);
        $display("test pin flags done");
        host.wr(8'h0B, 8'hFF);
        host.wr(8'h0A, 8'h01);
        host.wr(8'h09, 8'h05);
        pulse(5'h01, 8'h00);
        await(1'h1);
        rdchk(8'h09, 8'h05);
        host.wr(8'h09, 8'h04);
        await(1'h0);
        host.wr(8'h09, 8'h00);
        repeat (6) @(negedge ref_clk_i);
        await(1'h1);
        host.wr(8'h09, 8'h01);
        await(1'h0);
        host.wr(8'h0B, 8'hFF);
        host.wr(8'h09, 8'h07);
        repeat (4) @(negedge ref_clk_i);
        pulse(5'h01, 8'h00);
        n = 0;
        for (i = 0; i < 40; i++)
        begin
            @(negedge ref_clk_i);
            n += int'(irq === 1'h1);
        end
        chk(8'(n), 8'(`EDGE_PULSE_CYCLES));
        $display("test pin signalling done");
        results();
    end
endmodule : touch_expander_irq_core_tb_top

// File: touch_irq_map.svh
/*
 * Register offsets, field positions, reset values and timing counts of the
 * interrupt block. Assumes an 8-bit register address space.
 */
`ifndef TOUCH_IRQ_MAP_SVH
`define TOUCH_IRQ_MAP_SVH

`define IRQ_CTRL_ADDR        8'h09
`define IRQ_SOURCE_EN_ADDR   8'h0A
`define IRQ_SOURCE_STA_ADDR  8'h0B
`define PIN_IRQ_MASK_ADDR    8'h0C
`define PIN_IRQ_FLAGS_ADDR   8'h0D

`define IRQ_CTRL_RESET       3'h0
`define IRQ_SOURCE_EN_RESET  8'h00
`define IRQ_SOURCE_STA_RESET 8'h10
`define PIN_IRQ_MASK_RESET   8'h10
`define PIN_IRQ_FLAGS_RESET  8'h00

`define CTRL_GLOBAL_BIT      0
`define CTRL_TYPE_BIT        1
`define CTRL_POLARITY_BIT    2

`define SRC_PIN_BIT          7
`define SRC_CONV_BIT         6
`define SRC_RESERVED_BIT     5
`define SRC_EMPTY_BIT        4
`define SRC_FULL_BIT         3
`define SRC_OVERRUN_BIT      2
`define SRC_LEVEL_BIT        1
`define SRC_CONTACT_BIT      0

`define CLK_MHZ              25
`define EDGE_PULSE_NS        1000
`define EDGE_PULSE_CYCLES    ((`EDGE_PULSE_NS * `CLK_MHZ + 999) / 1000)

`endif

// File: touch_irq_pkg.sv
/*
 * Types shared by the interrupt block.
 * Assumes touch_irq_map.svh supplies the numeric constants.
 */
package touch_irq_pkg;

    typedef logic [7:0] reg_byte_t;
    typedef logic [4:0] pulse_cnt_t;

    typedef enum logic [1:0]
    {
        PIN_IDLE  = 2'b00,
        PIN_LEVEL = 2'b01,
        PIN_PULSE = 2'b10
    } pin_state_e;

endpackage : touch_irq_pkg

// File: touch_irq_sva.sv
/*
 * Port checker of the interrupt block.
 * Assumes one clock and single-cycle register strobes.
 */
`timescale 1ns/10ps
module touch_irq_sva
    import touch_irq_pkg::*;
(
    input wire logic      ref_clk_i,
    input wire logic      arst_n_i,
    input wire reg_byte_t reg_addr_i,
    input wire reg_byte_t reg_wdata_i,
    input wire logic      reg_wr_i,
    input wire logic      reg_rd_i,
    input wire reg_byte_t reg_rdata_o,
    input wire logic      contact_sensed_evt_i,
    input wire reg_byte_t pin_evt_i,
    input wire reg_byte_t queue_fill_i,
    input wire reg_byte_t queue_threshold_i,
    input wire logic      irq_o
);
    reg_byte_t  en_reg, en_next, mask_reg, mask_next;
    logic [2:0] ctrl_reg, ctrl_next, quiet_reg, quiet_next;
    always_comb
    begin
        en_next    = en_reg;
        mask_next  = mask_reg;
        ctrl_next  = ctrl_reg;
        quiet_next = quiet_reg + {2'h0, quiet_reg != 3'h7};
        if (reg_wr_i && reg_addr_i == 8'h09)
        begin
            ctrl_next  = reg_wdata_i[2:0];
            quiet_next = 3'h0;
        end
        if (reg_wr_i && reg_addr_i == 8'h0A)
            en_next = reg_wdata_i & 8'hDF;
        if (reg_wr_i && reg_addr_i == 8'h0C)
            mask_next = reg_wdata_i;
    end
    always_ff @(posedge ref_clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
            {en_reg, mask_reg, ctrl_reg, quiet_reg} <= {8'h00, 8'h10, 6'h00};
        else
            {en_reg, mask_reg, ctrl_reg, quiet_reg} <= {en_next, mask_next, ctrl_next, quiet_next};
    end
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!arst_n_i);
    sequence rd_at(a);
        reg_rd_i && !reg_wr_i && reg_addr_i == a;
    endsequence
    sequence reach_thr;
        queue_fill_i < queue_threshold_i ##1 queue_fill_i == queue_threshold_i;
    endsequence
    AST_EN_RB: assert property (rd_at(8'h0A) |=> reg_rdata_o == $past(en_reg))
        else $error("enable readback wrong");
    AST_RSV5: assert property (rd_at(8'h0B) |=> !reg_rdata_o[5])
        else $error("reserved status bit set");
    AST_MASK_RB: assert property (rd_at(8'h0C) |=> reg_rdata_o == $past(mask_reg))
        else $error("mask readback wrong");
    AST_STA_SET: assert property (contact_sensed_evt_i ##2 rd_at(8'h0B) |=> reg_rdata_o[0])
        else $error("contact status not latched");
    AST_LVL_SET: assert property (reach_thr ##1 rd_at(8'h0B) |=> reg_rdata_o[1])
        else $error("level status not set");
    AST_PIN_FLAG: assert property (pin_evt_i[0] ##2 rd_at(8'h0D) |=> reg_rdata_o[0])
        else $error("pin flag not latched");
    // Gate check waits out the pin pipeline after a control write
    AST_GATE: assert property (quiet_reg == 3'h7 && !ctrl_reg[0] |-> irq_o == !ctrl_reg[2])
        else $error("pin active with gate off");
    AST_LVL_IRQ: assert property (contact_sensed_evt_i && ctrl_reg == 3'h5 && en_reg[0] |-> ##[1:4] irq_o)
        else $error("level pin not raised");
endmodule : touch_irq_sva
bind touch_expander_irq_core touch_irq_sva sva_i (.ref_clk_i(ref_clk_i), .arst_n_i(arst_n_i),
    .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_rdata_o(reg_rdata_o), .contact_sensed_evt_i(contact_sensed_evt_i), .pin_evt_i(pin_evt_i),
    .queue_fill_i(queue_fill_i), .queue_threshold_i(queue_threshold_i), .irq_o(irq_o));
